// [src/roa_pkg.sv]
// Shared types and constants for the rule output action unit
package roa_pkg;

   // ===========================================
   // Sizes
   // ===========================================
   localparam int unsigned SLOT_COUNT     = 3;
   localparam int unsigned TIMER_COUNT    = 16;
   localparam int unsigned TIMER_IDX_W    = 4;
   localparam int unsigned ICNT_COUNT     = 8;
   localparam int unsigned ICNT_IDX_W     = 3;
   localparam int unsigned CHAN_W         = 4;
   localparam int unsigned AVAL_W         = 16;
   localparam int unsigned SPAN_W         = 3;
   localparam int unsigned FLAG_IDX_W     = 5;
   localparam int unsigned MSG_IDX_W      = 8;
   localparam int unsigned BURST_W        = 16;
   localparam int unsigned TIMER_W        = 32;
   localparam int unsigned ICNT_W         = 32;
   localparam int unsigned DEST_W         = 4;

   // ===========================================
   // Action kinds
   // ===========================================
   typedef enum logic [3:0] {
      ROA_ACT_NOP   = 4'h0,
      ROA_ACT_ANALOG= 4'h1,
      ROA_ACT_DOUT  = 4'h2,
      ROA_ACT_ICC   = 4'h3,
      ROA_ACT_PULSE = 4'h4,
      ROA_ACT_TIMER = 4'h5,
      ROA_ACT_FLAG  = 4'h6,
      ROA_ACT_NOTICE= 4'h7,
      ROA_ACT_ICNT  = 4'h8
   } roa_act_t;

   // Sub-mode codes, meaning depends on action kind
   localparam logic [1:0] SUB_CNT_START   = 2'h0;
   localparam logic [1:0] SUB_CNT_STOP    = 2'h1;
   localparam logic [1:0] SUB_CNT_RESET   = 2'h2;
   localparam logic [1:0] SUB_PLS_CONT    = 2'h0;
   localparam logic [1:0] SUB_PLS_STOP    = 2'h1;
   localparam logic [1:0] SUB_PLS_BURST   = 2'h2;
   localparam logic [1:0] SUB_TMR_ASSERT  = 2'h0;
   localparam logic [1:0] SUB_TMR_DEASSRT = 2'h1;
   localparam logic [1:0] SUB_IC_EDGE     = 2'h0;
   localparam logic [1:0] SUB_IC_RESET    = 2'h1;

   // Counter channel command codes on the output
   localparam logic [1:0] CCMD_START = 2'h0;
   localparam logic [1:0] CCMD_STOP  = 2'h1;
   localparam logic [1:0] CCMD_RESET = 2'h2;

   // Pulse command codes on the output
   localparam logic [1:0] PCMD_CONT  = 2'h0;
   localparam logic [1:0] PCMD_STOP  = 2'h1;
   localparam logic [1:0] PCMD_BURST = 2'h2;

   // ===========================================
   // Slot configuration
   // ===========================================
   typedef struct packed {
      roa_act_t              kind;
      logic [1:0]            sub;
      logic                  level;
      logic [CHAN_W-1:0]     chan;
      logic [DEST_W-1:0]     dest;
      logic [SPAN_W-1:0]     analog_span_select;
      logic [AVAL_W-1:0]     aval;
      logic [BURST_W-1:0]    finite_burst;
      logic [FLAG_IDX_W-1:0] flag_idx;
      logic [MSG_IDX_W-1:0]  msg_idx;
   } roa_cfg_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [CHAN_W-1:0]     chan;
      logic [SPAN_W-1:0]     span;
      logic [AVAL_W-1:0]     value;
   } roa_analog_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [CHAN_W-1:0]     chan;
      logic                  level;
   } roa_dout_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [CHAN_W-1:0]     chan;
      logic [1:0]            cmd;
   } roa_ccmd_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [CHAN_W-1:0]     chan;
      logic [1:0]            cmd;
      logic [BURST_W-1:0]    count;
   } roa_pcmd_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [FLAG_IDX_W-1:0] idx;
      logic                  value;
   } roa_flag_t;

   typedef struct packed {
      logic                  valid;
      logic [DEST_W-1:0]     dest;
      logic [MSG_IDX_W-1:0]  idx;
   } roa_notice_t;

endpackage : roa_pkg

// [src/roa_unit.sv]
// Rule output action unit: three action slots driven by one rule result
module roa_unit
   import roa_pkg::*;
#(
   parameter int unsigned SLOTS = SLOT_COUNT
)
(
   // Clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   // Execution stage hand-over
   input  wire logic                          i_exec_strobe,
   input  wire logic                          i_exec_result,
   // Slot configuration
   input  wire roa_cfg_t [SLOTS-1:0]          i_cfg,
   // Timer and internal counter read-back selection
   input  wire logic [TIMER_IDX_W-1:0]        i_timer_sel,
   input  wire logic [ICNT_IDX_W-1:0]         i_icnt_sel,
   // Action outputs, one per slot
   output roa_analog_t [SLOTS-1:0]            o_analog_out_action,
   output roa_dout_t   [SLOTS-1:0]            o_dout,
   output roa_ccmd_t   [SLOTS-1:0]            o_input_channel_counter_control,
   output roa_pcmd_t   [SLOTS-1:0]            o_pulse,
   output roa_flag_t   [SLOTS-1:0]            o_internal_flag_write,
   output roa_notice_t [SLOTS-1:0]            o_remote_notice_send,
   // Local state read-back
   output logic [TIMER_COUNT-1:0]             o_timer_running,
   output logic [TIMER_W-1:0]                 o_timer_value,
   output logic [ICNT_W-1:0]                  o_icnt_value
);

   // ===========================================
   // Helpers
   // ===========================================
   // Counter channel command for a given result
   function automatic logic [2:0] ccmd_of(input logic [1:0] sub, input logic res);
      logic [2:0] r;
      r = {1'b0, CCMD_START};
      // Undefined command codes are refused for either result
      if (sub > SUB_CNT_RESET)
         r = {1'b0, CCMD_START};
      else if (res)
         r = {1'b1, sub};
      else if (sub == SUB_CNT_START)
         r = {1'b1, CCMD_STOP};
      else if (sub == SUB_CNT_STOP)
         r = {1'b1, CCMD_START};
      return r;
   endfunction : ccmd_of

   // Level for a result: configured level on true, its opposite on false
   function automatic logic level_of(input logic level, input logic res);
      return res ? level : ~level;
   endfunction : level_of

   // ===========================================
   // Result latch
   // ===========================================
   logic res_q;
   logic res_d;
   logic prev_q;
   logic prev_d;
   logic tick_q;
   logic tick_d;

   always_comb
   begin
      res_d  = res_q;
      prev_d = prev_q;
      tick_d = i_exec_strobe;
      if (i_exec_strobe)
      begin
         res_d  = i_exec_result;
         prev_d = res_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         res_q  <= 1'b0;
         prev_q <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         res_q  <= res_d;
         prev_q <= prev_d;
         tick_q <= tick_d;
      end
   end

   // ===========================================
   // Slot actions, timers and internal counters
   // ===========================================
   roa_analog_t [SLOTS-1:0]        ana_q, ana_d;
   roa_dout_t   [SLOTS-1:0]        dout_q, dout_d;
   roa_ccmd_t   [SLOTS-1:0]        ccmd_q, ccmd_d;
   roa_pcmd_t   [SLOTS-1:0]        pcmd_q, pcmd_d;
   roa_flag_t   [SLOTS-1:0]        flag_q, flag_d;
   roa_notice_t [SLOTS-1:0]        note_q, note_d;
   logic [TIMER_COUNT-1:0]         trun_q, trun_d;
   logic [TIMER_W-1:0]             tval_q [TIMER_COUNT];
   logic [TIMER_W-1:0]             tval_d [TIMER_COUNT];
   logic [ICNT_W-1:0]              icnt_q [ICNT_COUNT];
   logic [ICNT_W-1:0]              icnt_d [ICNT_COUNT];
   logic [TIMER_W-1:0]             tsel_d;
   logic [ICNT_W-1:0]              isel_d;
   logic [TIMER_W-1:0]             tsel_q;
   logic [ICNT_W-1:0]              isel_q;

   always_comb
   begin
      logic [2:0]              cc;
      logic [TIMER_IDX_W-1:0]  ti;
      logic [ICNT_IDX_W-1:0]   ci;
      cc = 3'h0;
      ti = '0;
      ci = '0;
      trun_d = trun_q;
      tval_d = tval_q;
      icnt_d = icnt_q;
      for (int s = 0; s < SLOTS; s++)
      begin
         ana_d[s]        = ana_q[s];
         ana_d[s].valid  = 1'b0;
         dout_d[s]       = dout_q[s];
         dout_d[s].valid = 1'b0;
         ccmd_d[s]       = ccmd_q[s];
         ccmd_d[s].valid = 1'b0;
         pcmd_d[s]       = pcmd_q[s];
         pcmd_d[s].valid = 1'b0;
         flag_d[s]       = flag_q[s];
         flag_d[s].valid = 1'b0;
         note_d[s]       = note_q[s];
         note_d[s].valid = 1'b0;
      end
      // Running timers accumulate every clock
      for (int t = 0; t < TIMER_COUNT; t++)
      begin
         if (trun_q[t])
            tval_d[t] = tval_q[t] + TIMER_W'(1);
      end
      // every slot sees the same latched result
      if (tick_q)
      begin
         for (int s = 0; s < SLOTS; s++)
         begin
            ti = i_cfg[s].chan[TIMER_IDX_W-1:0];
            ci = i_cfg[s].chan[ICNT_IDX_W-1:0];
            case (i_cfg[s].kind)
               ROA_ACT_ANALOG:
               begin
                  // drive on true, hold on false
                  if (res_q)
                     ana_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].chan,
                                  i_cfg[s].analog_span_select, i_cfg[s].aval};
               end
               ROA_ACT_DOUT:
               begin
                  dout_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].chan,
                                level_of(i_cfg[s].level, res_q)};
               end
               ROA_ACT_ICC:
               begin
                  cc = ccmd_of(i_cfg[s].sub, res_q);
                  if (cc[2])
                     ccmd_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].chan, cc[1:0]};
               end
               ROA_ACT_PULSE:
               begin
                  // act on true only; burst count handed to channel
                  if (res_q && i_cfg[s].sub <= SUB_PLS_BURST)
                     pcmd_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].chan, i_cfg[s].sub,
                                   i_cfg[s].finite_burst};
               end
               ROA_ACT_TIMER:
               begin
                  // run on active level, clear otherwise
                  if (res_q ^ (i_cfg[s].sub == SUB_TMR_DEASSRT))
                     trun_d[ti] = 1'b1;
                  else
                  begin
                     trun_d[ti] = 1'b0;
                     tval_d[ti] = '0;
                  end
               end
               ROA_ACT_FLAG:
               begin
                  flag_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].flag_idx,
                                level_of(i_cfg[s].level, res_q)};
               end
               ROA_ACT_NOTICE:
               begin
                  if (res_q)
                     note_d[s] = '{1'b1, i_cfg[s].dest, i_cfg[s].msg_idx};
               end
               ROA_ACT_ICNT:
               begin
                  if (i_cfg[s].sub == SUB_IC_EDGE && res_q && !prev_q)
                     icnt_d[ci] = icnt_d[ci] + ICNT_W'(1);
                  else if (i_cfg[s].sub == SUB_IC_RESET && res_q)
                     icnt_d[ci] = '0;
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ana_q  <= '0;
         dout_q <= '0;
         ccmd_q <= '0;
         pcmd_q <= '0;
         flag_q <= '0;
         note_q <= '0;
         trun_q <= '0;
         for (int t = 0; t < TIMER_COUNT; t++)
            tval_q[t] <= '0;
         for (int c = 0; c < ICNT_COUNT; c++)
            icnt_q[c] <= '0;
      end
      else
      begin
         ana_q  <= ana_d;
         dout_q <= dout_d;
         ccmd_q <= ccmd_d;
         pcmd_q <= pcmd_d;
         flag_q <= flag_d;
         note_q <= note_d;
         trun_q <= trun_d;
         tval_q <= tval_d;
         icnt_q <= icnt_d;
      end
   end

   // ===========================================
   // Read-back selection
   // ===========================================
   // Shows the value that the selected timer or counter takes at this edge
   always_comb
   begin
      tsel_d = tval_d[i_timer_sel];
      isel_d = icnt_d[i_icnt_sel];
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tsel_q <= '0;
         isel_q <= '0;
      end
      else
      begin
         tsel_q <= tsel_d;
         isel_q <= isel_d;
      end
   end

   // ===========================================
   // Outputs
   // ===========================================
   assign o_analog_out_action             = ana_q;
   assign o_dout                          = dout_q;
   assign o_input_channel_counter_control = ccmd_q;
   assign o_pulse                         = pcmd_q;
   assign o_internal_flag_write           = flag_q;
   assign o_remote_notice_send            = note_q;
   assign o_timer_running                 = trun_q;
   assign o_timer_value                   = tsel_q;
   assign o_icnt_value                    = isel_q;

endmodule : roa_unit

// [verif/roa_exec_model.sv]
// Execution stage model: hands one rule result per one-cycle strobe
module roa_exec_model
(
   input  wire logic i_clk,
   output logic      o_strobe,
   output logic      o_result
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      o_strobe = 1'b0;
      o_result = 1'b0;
   end
   task automatic send(input logic r);
      @(negedge i_clk);
      o_strobe = 1'b1;
      o_result = r;
      @(negedge i_clk);
      o_strobe = 1'b0;
      // Result is meaningless outside the strobe
      o_result = ~r;
   endtask : send
endmodule : roa_exec_model

// [verif/roa_unit_asserts.sv]
// Assertion checker for the rule output action unit
module roa_unit_asserts
   import roa_pkg::*;
#(
   parameter int unsigned SLOTS = SLOT_COUNT
)
(
   // Clock, reset and result
   input wire logic                  i_clk,
   input wire logic                  i_rst_n,
   input wire logic                  i_exec_strobe,
   input wire logic                  i_exec_result,
   input wire roa_cfg_t [SLOTS-1:0]  i_cfg,
   // Watched outputs
   input wire roa_analog_t [SLOTS-1:0] o_analog_out_action,
   input wire roa_dout_t [SLOTS-1:0] o_dout,
   input wire roa_ccmd_t [SLOTS-1:0] o_input_channel_counter_control,
   input wire roa_pcmd_t [SLOTS-1:0] o_pulse,
   input wire roa_flag_t [SLOTS-1:0] o_internal_flag_write,
   input wire roa_notice_t [SLOTS-1:0] o_remote_notice_send
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ===========================================
   // Slot action checks
   // ===========================================
   AST_ANALOG_SET: assert property (i_exec_strobe && i_exec_result
      && i_cfg[0].kind == ROA_ACT_ANALOG |-> ##2 o_analog_out_action[0].valid
      && o_analog_out_action[0].value == $past(i_cfg[0].aval, 2))
      else $error("analog value not driven on true");
   AST_ANALOG_HOLD: assert property (i_exec_strobe && !i_exec_result
      && i_cfg[0].kind == ROA_ACT_ANALOG |-> ##2 !o_analog_out_action[0].valid
      && $stable(o_analog_out_action[0].value))
      else $error("analog changed on false");
   AST_DOUT_LEVEL: assert property (i_exec_strobe && i_cfg[0].kind == ROA_ACT_DOUT
      |-> ##2 o_dout[0].valid && o_dout[0].level == $past(i_cfg[0].level ~^ i_exec_result, 2))
      else $error("discrete level wrong");
   AST_ICC_RESET_FALSE: assert property (i_exec_strobe && !i_exec_result
      && i_cfg[0].kind == ROA_ACT_ICC && i_cfg[0].sub == SUB_CNT_RESET
      |-> ##2 !o_input_channel_counter_control[0].valid)
      else $error("counter command after reset on false");
   AST_PULSE_FALSE: assert property (i_exec_strobe && !i_exec_result
      && i_cfg[0].kind == ROA_ACT_PULSE |-> ##2 !o_pulse[0].valid)
      else $error("pulse command on false");
   AST_FLAG_VALUE: assert property (i_exec_strobe && i_cfg[0].kind == ROA_ACT_FLAG
      |-> ##2 o_internal_flag_write[0].valid
      && o_internal_flag_write[0].value == $past(i_cfg[0].level ~^ i_exec_result, 2))
      else $error("flag value wrong");
   AST_NOTICE_IDX: assert property (i_exec_strobe && i_cfg[0].kind == ROA_ACT_NOTICE
      |-> ##2 o_remote_notice_send[0].valid == $past(i_exec_result, 2)
      && (!$past(i_exec_result, 2) || o_remote_notice_send[0].idx == $past(i_cfg[0].msg_idx, 2)))
      else $error("notice send or index wrong");
   AST_SLOT2_SAME: assert property (i_exec_strobe && i_cfg[2].kind == ROA_ACT_DOUT
      |-> ##2 o_dout[2].valid && o_dout[2].level == $past(i_cfg[2].level ~^ i_exec_result, 2))
      else $error("slot two missed the result");
   AST_NOP_QUIET: assert property (i_exec_strobe && i_cfg[1].kind == ROA_ACT_NOP
      |-> ##2 !(o_analog_out_action[1].valid || o_dout[1].valid || o_pulse[1].valid
      || o_input_channel_counter_control[1].valid || o_remote_notice_send[1].valid
      || o_internal_flag_write[1].valid))
      else $error("idle slot acted");
endmodule : roa_unit_asserts

bind roa_unit roa_unit_asserts #(.SLOTS(SLOTS)) chk_u (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_exec_strobe(i_exec_strobe),
   .i_exec_result(i_exec_result), .i_cfg(i_cfg), .o_analog_out_action(o_analog_out_action),
   .o_dout(o_dout), .o_input_channel_counter_control(o_input_channel_counter_control),
   .o_pulse(o_pulse), .o_internal_flag_write(o_internal_flag_write),
   .o_remote_notice_send(o_remote_notice_send));

// [verif/testbench.sv]
// Self-checking testbench for the rule output action unit
module testbench
   import roa_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst_n, stb, res;
   roa_cfg_t [2:0] cfg;
   logic [3:0] tsel;
   logic [2:0] isel;
   roa_analog_t [2:0] an;
   roa_dout_t [2:0] dout;
   roa_ccmd_t [2:0] ccmd;
   roa_pcmd_t [2:0] pcmd;
   roa_flag_t [2:0] flg;
   roa_notice_t [2:0] ntc;
   logic [15:0] trun;
   logic [31:0] tval, ival;
   int error_cnt, n_checks, cyc;
   roa_exec_model exec_u (.i_clk(i_clk), .o_strobe(stb), .o_result(res));
   roa_unit dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_exec_strobe(stb), .i_exec_result(res),
      .i_cfg(cfg), .i_timer_sel(tsel), .i_icnt_sel(isel), .o_analog_out_action(an),
      .o_dout(dout), .o_input_channel_counter_control(ccmd), .o_pulse(pcmd),
      .o_internal_flag_write(flg), .o_remote_notice_send(ntc), .o_timer_running(trun),
      .o_timer_value(tval), .o_icnt_value(ival));
   initial i_clk = 1'b0;
   always #12.5 i_clk = ~i_clk;
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         final_report;
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   // Strobe one result and stop just after the answer edge
   task automatic fire(input logic r);
      exec_u.send(r);
      @(negedge i_clk);
      check("idle slot", {an[1].valid, dout[1].valid, ccmd[1].valid, pcmd[1].valid,
         flg[1].valid, ntc[1].valid}, 32'h0);
   endtask : fire
   task automatic set0(input roa_act_t k, input logic [1:0] s);
      cfg[0] = '0;
      cfg[0].kind = k;
      cfg[0].sub = s;
   endtask : set0
   task automatic s_analog;
      set0(ROA_ACT_ANALOG, 2'h0);
      cfg[0].aval = 16'h1234;
      cfg[0].analog_span_select = 3'h5;
      cfg[0].chan = 4'h2;
      fire(1'b1);
      check("ao set", {an[0].valid, an[0].span, an[0].chan, an[0].value},
         {8'h0, 1'b1, 3'h5, 4'h2, 16'h1234});
      fire(1'b0);
      check("ao hold", {an[0].valid, an[0].value}, 32'h0_1234);
   endtask : s_analog
   task automatic s_dout;
      set0(ROA_ACT_DOUT, 2'h0);
      cfg[2] = '0;
      cfg[2].kind = ROA_ACT_DOUT;
      cfg[2].level = 1'b1;
      for (int i = 1; i >= 0; i--)
      begin
         fire(i[0]);
         check("do lvl", {dout[0].valid, dout[0].level, dout[2].valid, dout[2].level},
            {28'h0, 1'b1, ~i[0], 1'b1, i[0]});
      end
      cfg[2] = '0;
   endtask : s_dout
   task automatic s_icc_pulse;
      for (int s = 0; s < 3; s++)
      begin
         set0(ROA_ACT_ICC, s[1:0]);
         fire(1'b1);
         check("cc true", {ccmd[0].valid, ccmd[0].cmd}, {29'h0, 1'b1, s[1:0]});
         fire(1'b0);
         check("cc false", ccmd[0].valid, (s != 2));
         if (s != 2)
            check("cc swap", ccmd[0].cmd, (s == 0) ? CCMD_STOP : CCMD_START);
         set0(ROA_ACT_PULSE, s[1:0]);
         cfg[0].finite_burst = 16'h0005;
         fire(1'b1);
         check("pl true", {pcmd[0].valid, pcmd[0].cmd}, {29'h0, 1'b1, s[1:0]});
         if (s == 2)
            check("pl burst", pcmd[0].count, 32'h5);
         fire(1'b0);
         check("pl false", pcmd[0].valid, 32'h0);
      end
   endtask : s_icc_pulse
   task automatic s_timer;
      set0(ROA_ACT_TIMER, SUB_TMR_ASSERT);
      cfg[0].chan = 4'hF;
      fire(1'b1);
      check("tm run", trun, 32'h8000);
      repeat (4) @(negedge i_clk);
      check("tm count", tval, 32'h4);
      fire(1'b0);
      @(negedge i_clk);
      check("tm clear", tval, 32'h0);
      check("tm stop", trun, 32'h0);
      cfg[0].sub = SUB_TMR_DEASSRT;
      fire(1'b0);
      check("tm run f", trun, 32'h8000);
      fire(1'b1);
      @(negedge i_clk);
      check("tm clear t", tval, 32'h0);
      check("tm stop t", trun, 32'h0);
   endtask : s_timer
   task automatic s_flag_notice;
      set0(ROA_ACT_FLAG, 2'h0);
      cfg[0].level = 1'b1;
      cfg[0].flag_idx = 5'h1F;
      for (int i = 1; i >= 0; i--)
      begin
         fire(i[0]);
         check("flag", {flg[0].valid, flg[0].idx, flg[0].value}, {25'h1, 5'h1F, i[0]});
      end
      set0(ROA_ACT_NOTICE, 2'h0);
      cfg[0].msg_idx = 8'hA5;
      fire(1'b1);
      check("notice", {ntc[0].valid, ntc[0].idx}, 32'h1A5);
      fire(1'b0);
      check("notice f", ntc[0].valid, 32'h0);
   endtask : s_flag_notice
   task automatic s_icnt;
      logic [4:0]  rs;
      logic [31:0] ex;
      rs = 5'b10110;
      set0(ROA_ACT_ICNT, SUB_IC_RESET);
      cfg[0].chan = 4'h7;
      fire(1'b1);
      cfg[0].sub = SUB_IC_EDGE;
      ex = 0;
      for (int i = 0; i < 5; i++)
      begin
         fire(rs[i]);
         if (rs[i] && (i == 0 || !rs[i-1]))
            ex++;
         @(negedge i_clk);
         check("ic edge", ival, ex);
      end
      cfg[0].sub = SUB_IC_RESET;
      fire(1'b0);
      @(negedge i_clk);
      check("ic keep", ival, ex);
      fire(1'b1);
      @(negedge i_clk);
      check("ic clear", ival, 32'h0);
   endtask : s_icnt
   initial
   begin
      i_rst_n = 1'b0;
      cfg = '0;
      tsel = 4'hF;
      isel = 3'h7;
      repeat (8) @(negedge i_clk);
      i_rst_n = 1'b1;
      s_analog;
      s_dout;
      s_icc_pulse;
      s_timer;
      s_flag_notice;
      s_icnt;
      final_report;
   end
endmodule : testbench
